/* File: design/rtc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.svh"

// Behaviour
// - Eight-bit up counter, double-buffered reload
// - Overflow keeps counting, raises timeout request
// - Non-PWM overflow is all-ones to zero, or to reload if enabled
// - Event mode counts each pin falling edge
// - Mode bit 3 picks internal or pin
// - Pin source ignores prescale, clears pin flag
// - Prescale code 000 /256 down to /2
// - Run bit stops or starts counting
// - PWM enable bit; boundary from two bits
// - Toggle enable drives pin with toggle
// - Reload enable gates overflow auto-reload
// - Aux bit 2 hands source to divider
// - Divider bit: oscillator /2 or /1
// - Internal PWM boundary 256/64/32/16
// - Short boundaries use only low bits
// - Auto-reload copies reload on overflow
// - Reload write waits in holding buffer
// - PWM mode always reloads
// - Toggle flips at each overflow
// - PWM high while count below reload
// - Reload zero keeps PWM low
module rtc_timer
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // Avalon-MM slave
  input  wire logic [`RTC_ADDR_W-1:0]  avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [`RTC_DATA_W-1:0]  avs_writedata_i,
  input  wire logic [`RTC_BE_W-1:0]    avs_byteenable_i,
  output logic      [`RTC_DATA_W-1:0]  avs_readdata_o,
  output logic                         avs_waitrequest_o,
  // Count sources
  input  wire logic                    fcpu_tick_i,
  input  wire logic                    hosc_tick_i,
  input  wire logic                    ext_event_pin_i,
  // Event pin flag
  input  wire logic                    pin_irq_clr_i,
  output logic                         pin_irq_flag_o,
  // General I/O path of the shared pin
  input  wire logic                    gpio_out_i,
  input  wire logic                    gpio_oe_i,
  // Shared pin and timeout
  output logic                         toggle_pwm_pin_o,
  output logic                         toggle_pwm_pin_oe_o,
  output logic                         timeout_irq_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  // Registers
  rtc_mode_t   mode_q;
  rtc_aux_t    aux_q;
  logic [7:0]  count_q;
  logic [7:0]  count_d;
  logic [7:0]  hold_q;
  logic [7:0]  active_q;
  logic        toggle_q;

  // Bus side
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        sel_reload;
  logic        sel_aux;
  logic        sel_mode;
  logic        sel_count;
  logic        wr_go;
  logic        rd_go;
  logic        lane0;

  // Count sources
  logic [7:0]  pre_q;
  logic [7:0]  pre_mask;
  logic        pre_tick;
  logic        hdiv_q;
  logic        hosc_cnt_tick;
  logic        use_ext;
  logic        use_hosc;
  logic        cnt_tick;

  // Event pin synchroniser
  logic        sync1_q;
  logic        sync2_q;
  logic        prev_q;
  logic        pin_fall;

  // Boundary and outputs
  logic [7:0]  bmask;
  logic        ovf;
  logic        reload_act;
  logic        pwm_level;
  logic        pin_d;
  logic        oe_d;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // One wait cycle so read data is registered
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_go     = avs_write_i & ack_q;
  assign rd_go     = avs_read_i & ~ack_q;
  assign lane0     = avs_byteenable_i[0];

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Full decode, so aliases read zero
  assign sel_reload = avs_address_i == {`RTC_IDX_RELOAD, `RTC_IDX_PAD};
  assign sel_aux   = avs_address_i == {`RTC_IDX_AUX, `RTC_IDX_PAD};
  assign sel_mode  = avs_address_i == {`RTC_IDX_MODE, `RTC_IDX_PAD};
  assign sel_count = avs_address_i == {`RTC_IDX_COUNT, `RTC_IDX_PAD};

  // Reload is write-only; unmapped reads zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= {`RTC_RD_PAD, `RTC_RST_BYTE};
    end else if (rd_go) begin
      if (sel_aux) begin
        rdata_q <= {`RTC_RD_PAD, aux_q};
      end else if (sel_mode) begin
        rdata_q <= {`RTC_RD_PAD, mode_q};
      end else if (sel_count) begin
        rdata_q <= {`RTC_RD_PAD, count_q};
      end else begin
        rdata_q <= {`RTC_RD_PAD, `RTC_RST_BYTE};
      end
    end
  end

  assign avs_readdata_o = rdata_q;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Whole byte writable, read back as stored
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= rtc_mode_t'(`RTC_RST_BYTE);
    end else if (wr_go & lane0 & sel_mode) begin
      mode_q <= rtc_mode_t'(avs_writedata_i[7:0]);
    end
  end

  // Reserved aux bits stay zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aux_q <= rtc_aux_t'(`RTC_RST_BYTE);
    end else if (wr_go & lane0 & sel_aux) begin
      aux_q <= rtc_aux_t'(avs_writedata_i[7:0] & `RTC_AUX_WMASK);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_q <= `RTC_RST_BYTE;
    end else if (wr_go & lane0 & sel_reload) begin
      hold_q <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_q <= `RTC_RST_BYTE;
    end else if (ovf) begin
      active_q <= hold_q;
    end
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // divisor 256 >> code
  assign pre_mask = `RTC_FULL_MASK >> mode_q.rate;
  assign pre_tick = fcpu_tick_i & ((pre_q & pre_mask) == pre_mask);

  // Cleared while stopped for a clean first period
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_q <= `RTC_RST_BYTE;
    end else if (!mode_q.run) begin
      pre_q <= `RTC_RST_BYTE;
    end else if (fcpu_tick_i) begin
      pre_q <= pre_q + `RTC_ONE;
    end
  end

  // Free-running, so a first halved period may be short
  // oscillator divide by two or one
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hdiv_q <= 1'b0;
    end else if (hosc_tick_i) begin
      hdiv_q <= ~hdiv_q;
    end
  end

  assign hosc_cnt_tick = hosc_tick_i & (aux_q.div_sel | hdiv_q);

  // ----------------------------------------
  // Event pin
  // ----------------------------------------
  // Reset high matches the idle pin: no false edge
  // two-flop sync then edge detect
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= ext_event_pin_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign pin_fall = prev_q & ~sync2_q;

  // An edge beats a clear in the same cycle
  // flag forced low under pin source
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_irq_flag_o <= 1'b0;
    end else if (use_ext) begin
      pin_irq_flag_o <= 1'b0;
    end else if (pin_fall) begin
      pin_irq_flag_o <= 1'b1;
    end else if (pin_irq_clr_i) begin
      pin_irq_flag_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  // aux path bit overrides mode bit
  assign use_hosc = aux_q.path_sel;
  // mode bit picks pin or internal
  assign use_ext  = ~aux_q.path_sel & mode_q.ext_sel;

  always_comb begin
    if (use_hosc) begin
      cnt_tick = hosc_cnt_tick;
    end else if (use_ext) begin
      cnt_tick = pin_fall;
    end else begin
      cnt_tick = pre_tick;
    end
    cnt_tick = cnt_tick & mode_q.run;
  end

  // ----------------------------------------
  // Boundary
  // ----------------------------------------
  // Pin source keeps the full 256 boundary
  // PWM boundary only on internal clock
  always_comb begin
    bmask = `RTC_FULL_MASK;
    if (mode_q.pwm_en & ~use_ext) begin
      case (rtc_bound_t'({mode_q.reload_en, mode_q.toggle_en}))
        RTC_B256: bmask = `RTC_FULL_MASK;
        RTC_B64:  bmask = `RTC_MASK_64;
        RTC_B32:  bmask = `RTC_MASK_32;
        RTC_B16:  bmask = `RTC_MASK_16;
        default:  bmask = `RTC_FULL_MASK;
      endcase
    end
  end

  assign ovf = cnt_tick & ((count_q & bmask) == bmask);

  assign reload_act = mode_q.pwm_en | mode_q.reload_en;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Masked increment keeps short boundaries wrapping
  // wrap or reload, keep counting
  always_comb begin
    count_d = count_q;
    if (ovf) begin
      count_d = reload_act ? (active_q & bmask) : `RTC_RST_BYTE;
    end else if (cnt_tick) begin
      count_d = (count_q + `RTC_ONE) & bmask;
    end
  end

  // Software write to the count wins over a tick
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_q <= `RTC_RST_BYTE;
    end else if (wr_go & lane0 & sel_count) begin
      count_q <= avs_writedata_i[7:0];
    end else begin
      count_q <= count_d;
    end
  end

  // Registered, so it trails the overflow by a cycle
  // one-cycle timeout request
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timeout_irq_o <= 1'b0;
    end else begin
      timeout_irq_o <= ovf;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // toggle at each overflow
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      toggle_q <= 1'b0;
    end else if (ovf) begin
      toggle_q <= ~toggle_q;
    end
  end

  // Level is ignored unless the pin is in PWM
  // compare on significant bits
  assign pwm_level = (count_q & bmask) < (active_q & bmask);

  // PWM first, then toggle, else I/O
  always_comb begin
    if (mode_q.pwm_en) begin
      pin_d = pwm_level;
      oe_d  = 1'b1;
    end else if (mode_q.toggle_en) begin
      pin_d = toggle_q;
      oe_d  = 1'b1;
    end else begin
      pin_d = gpio_out_i;
      oe_d  = gpio_oe_i;
    end
  end

  // Registered pin avoids compare glitches
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      toggle_pwm_pin_o    <= 1'b0;
      toggle_pwm_pin_oe_o <= 1'b0;
    end else begin
      toggle_pwm_pin_o    <= pin_d;
      toggle_pwm_pin_oe_o <= oe_d;
    end
  end

endmodule

`default_nettype wire

/* File: common/rtc_map.svh */
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define RTC_IDX_RELOAD   8'hCD
`define RTC_IDX_AUX      8'hD8
`define RTC_IDX_MODE     8'hDA
`define RTC_IDX_COUNT    8'hDB

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define RTC_RST_BYTE     8'h00
`define RTC_AUX_WMASK    8'hF6
`define RTC_BYTE_ONES    8'hFF
`define RTC_FULL_MASK    8'hFF
`define RTC_MASK_64      8'h3F
`define RTC_MASK_32      8'h1F
`define RTC_MASK_16      8'h0F
`define RTC_ONE          8'h01

// ----------------------------------------
// Bus shape
// ----------------------------------------
`define RTC_ADDR_W       10
`define RTC_DATA_W       32
`define RTC_BE_W         4
`define RTC_IDX_PAD      2'h0
`define RTC_RD_PAD       24'h000000

// ----------------------------------------
// Clock
// ----------------------------------------
`define RTC_CLK_MHZ      20

`endif

/* File: common/rtc_pkg.sv */
package rtc_pkg;

  // ----------------------------------------
  // Field layouts, bit 7 first
  // ----------------------------------------
  typedef struct packed {
    logic       run;
    logic [2:0] rate;
    logic       ext_sel;
    logic       reload_en;
    logic       toggle_en;
    logic       pwm_en;
  } rtc_mode_t;

  typedef struct packed {
    logic [3:0] other_timer;
    logic       rsvd3;
    logic       path_sel;
    logic       div_sel;
    logic       rsvd0;
  } rtc_aux_t;

  // PWM boundary code {reload_en, toggle_en}
  typedef enum logic [1:0] {
    RTC_B256,
    RTC_B64,
    RTC_B32,
    RTC_B16
  } rtc_bound_t;

endpackage

/* File: testbench/rtc_timer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_timer_chk
  import rtc_pkg::*;
(
  // Bus
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [9:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Pins
  input wire logic        gpio_oe_i,
  input wire logic        pin_irq_flag_o,
  input wire logic        toggle_pwm_pin_o,
  input wire logic        toggle_pwm_pin_oe_o,
  input wire logic        timeout_irq_o
);
  // Shadow of the mode register, fed by completed writes
  rtc_mode_t mode_q;
  logic      drv;
  logic      tg;
  logic      path_q;
  logic      ext_act;
  assign ext_act = mode_q.ext_sel & ~path_q;
  assign drv = mode_q.pwm_en | mode_q.toggle_en;
  assign tg  = mode_q.toggle_en & ~mode_q.pwm_en;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= '0;
    end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 10'h368) begin
      mode_q <= rtc_mode_t'(avs_writedata_i[7:0]);
    end
  end
  // Aux path bit takes the source away from the pin
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      path_q <= 1'b0;
    end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 10'h360) begin
      path_q <= avs_writedata_i[2];
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  wait_state_a: assert property (
    $rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bad wait state");
  unmap_zero_a: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i != 10'h360
    && avs_address_i != 10'h368 && avs_address_i != 10'h36C
    |-> avs_readdata_o == 32'h00000000) else $error("read not zero");
  mode_read_a: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == 10'h368
    |-> avs_readdata_o[7:0] == mode_q) else $error("bad mode read");
  flag_held_a: assert property (
    ext_act && $past(ext_act) |-> !pin_irq_flag_o) else $error("pin flag set");
  stop_quiet_a: assert property (
    !mode_q.run && !$past(mode_q.run) |-> !timeout_irq_o) else $error("timeout when stopped");
  pin_drive_a: assert property (
    drv && $past(drv) |-> toggle_pwm_pin_oe_o) else $error("pin not driven");
  gpio_pass_a: assert property (
    !drv && !$past(drv) |-> toggle_pwm_pin_oe_o == $past(gpio_oe_i))
    else $error("bad gpio enable");
  tog_flip_a: assert property (
    timeout_irq_o && tg && $past(tg, 2) |=> toggle_pwm_pin_o != $past(toggle_pwm_pin_o))
    else $error("no toggle");
endmodule
bind rtc_timer rtc_timer_chk u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .gpio_oe_i(gpio_oe_i), .pin_irq_flag_o(pin_irq_flag_o),
  .toggle_pwm_pin_o(toggle_pwm_pin_o), .toggle_pwm_pin_oe_o(toggle_pwm_pin_oe_o),
  .timeout_irq_o(timeout_irq_o));
`default_nettype wire

/* File: testbench/rtc_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_src_model (
  // Clock
  input  wire logic clk_i,
  // Count sources
  output logic      fcpu_tick_o,
  output logic      hosc_tick_o,
  output logic      pin_o
);
  // Strobes always on: shortest prescale runs
  assign fcpu_tick_o = 1'b1;
  assign hosc_tick_o = 1'b1;
  initial pin_o = 1'b1;
  // Six clocks a level, past the synchroniser delay
  task automatic fall(input int k);
    repeat (k) begin
      @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (6) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

/* File: testbench/rtc_timer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_timer_tb_top;
  localparam logic [9:0] RL = 10'h334;
  localparam logic [9:0] AX = 10'h360;
  localparam logic [9:0] MD = 10'h368;
  localparam logic [9:0] CT = 10'h36C;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic        clr       = 1'b0;
  logic        g_e       = 1'b0;
  logic [9:0]  adr       = 10'h000;
  logic [31:0] wd        = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        wt, f_t, h_t, pin, flag, po, irq;
  int          err_count = 0;
  int          n_checks  = 0;
  int          n;
  rtc_src_model src (.clk_i(clk_i), .fcpu_tick_o(f_t), .hosc_tick_o(h_t), .pin_o(pin));
  rtc_timer uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'h1),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .fcpu_tick_i(f_t), .hosc_tick_i(h_t),
    .ext_event_pin_i(pin), .pin_irq_clr_i(clr), .pin_irq_flag_o(flag), .gpio_out_i(g_e),
    .gpio_oe_i(g_e), .toggle_pwm_pin_o(po), .toggle_pwm_pin_oe_o(), .timeout_irq_o(irq));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Waits for the answer; only the watchdog ends a hang
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    adr <= a;
    wd <= {24'h000000, d};
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk_i);
    end while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(q, {24'h000000, e});
  endtask
  // Cycles up to the next timeout pulse
  task automatic gap();
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    chk(irq, 1'b1);
  endtask
  task automatic s_regs();
    rdc(MD, 8'h00);
    rdc(CT, 8'h00);
    acc(1'b1, RL, 8'h55);
    rdc(RL, 8'h00);
    rdc(10'h100, 8'h00);
    acc(1'b1, AX, 8'hFF);
    rdc(AX, 8'hF6);
  endtask
  task automatic s_timer();
    acc(1'b1, RL, 8'hFC);
    acc(1'b1, CT, 8'hFC);
    acc(1'b1, MD, 8'h86);
    gap();
    gap();
    chk(n, 32'h100);
    gap();
    chk(n, 32'h4);
    acc(1'b1, AX, 8'h04);
    gap();
    gap();
    chk(n, 32'h8);
    acc(1'b1, MD, 8'h82);
    gap();
    gap();
    gap();
    chk(n, 32'h200);
    acc(1'b1, MD, 8'h02);
    acc(1'b0, CT, 8'h00);
    repeat (30) @(posedge clk_i);
    rdc(CT, q[7:0]);
  endtask
  task automatic s_rate();
    acc(1'b1, AX, 8'h00);
    // Short start so the slowest rate fits the gap limit
    acc(1'b1, CT, 8'hFC);
    for (int r = 0; r < 8; r++) begin
      acc(1'b1, MD, {1'b1, r[2:0], 4'h4});
      gap();
      gap();
      gap();
      chk(n, 4 << (8 - r));
    end
  endtask
  task automatic s_event();
    acc(1'b1, MD, 8'h00);
    g_e <= 1'b1;
    src.fall(1);
    chk(flag, 1'b1);
    chk(po, 1'b1);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    @(posedge clk_i);
    chk(flag, 1'b0);
    acc(1'b1, CT, 8'hFE);
    acc(1'b1, MD, 8'h88);
    src.fall(2);
    rdc(CT, 8'h00);
    src.fall(3);
    rdc(CT, 8'h03);
  endtask
  // Count restarts at zero, then high cycles in sixteen
  task automatic duty(input logic [7:0] e);
    acc(1'b1, CT, 8'h00);
    n = 0;
    repeat (16) begin
      @(posedge clk_i);
      n += int'(po === 1'b1);
    end
    chk(n, {24'h000000, e});
  endtask
  task automatic s_pwm();
    int nb;
    acc(1'b1, AX, 8'h06);
    acc(1'b1, RL, 8'h14);
    for (int b = 0; b < 4; b++) begin
      nb = (b == 0) ? 256 : (128 >> b);
      acc(1'b1, MD, {1'b1, 4'h0, b[1:0], 1'b1});
      gap();
      gap();
      gap();
      chk(n, nb - (8'h14 & (nb - 1)));
    end
    duty(8'h04);
    acc(1'b1, RL, 8'h00);
    gap();
    gap();
    duty(8'h00);
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Twice the longest expected run
  initial begin
    #1000000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    s_regs();
    s_timer();
    s_rate();
    s_event();
    s_pwm();
    complete_run();
  end
endmodule
`default_nettype wire
